// file: inc/spc_pkg.sv
// Package for the serial port control block: offsets, fields, codes and carriers
package spc_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [3:0] SPC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SPC_ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0] SPC_ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0] SPC_ADDR_FORMAT = 4'h3;
  localparam logic [3:0] SPC_ADDR_PORT_STAT = 4'h4;

  // ******************************************************************
  // Control register fields
  // ******************************************************************
  localparam int SPC_BIT_TX_IRQ_ALLOW = 7;
  localparam int SPC_BIT_RX_IRQ_ALLOW = 6;
  localparam int SPC_BIT_TX_ALLOW = 5;
  localparam int SPC_BIT_RX_ALLOW = 4;
  localparam int SPC_BIT_ADDR_FILTER_WAIT = 3;
  localparam int SPC_BIT_TX_DONE_IRQ_ALLOW = 2;
  localparam logic [7:0] SPC_CTRL_RESET = 8'h00;

  // Format register fields
  localparam int SPC_BIT_COMM_MODE = 7;
  localparam int SPC_BIT_MULTIPROC_MODE = 2;
  localparam logic [7:0] SPC_FORMAT_RESET = 8'h00;

  // Sticky interrupt status bits
  localparam int SPC_EV_TX_EMPTY = 0;
  localparam int SPC_EV_RX_FULL = 1;
  localparam int SPC_EV_RX_ERROR = 2;
  localparam int SPC_EV_TX_END = 3;
  localparam logic [3:0] SPC_EV_RESET = 4'h0;

  // ******************************************************************
  // Clock source codes and pin modes
  // ******************************************************************
  localparam logic [1:0] SPC_CKS_INT = 2'h0;
  localparam logic [1:0] SPC_CKS_INT_OUT = 2'h1;
  localparam logic [1:0] SPC_CKS_EXT = 2'h2;
  localparam logic [1:0] SPC_CKS_RSVD = 2'h3;
  localparam int SPC_EXT_OVERSAMPLE = 16;

  typedef enum logic [1:0] {
    SPC_CLK_INTERNAL = 2'b00,
    SPC_CLK_DRIVE_OUT = 2'b01,
    SPC_CLK_EXTERNAL = 2'b11,
    SPC_CLK_RESERVED = 2'b10
  } spc_clk_mode_type;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_finished_flag;
    logic rx_data_full_flag;
    logic overrun_flag;
    logic frame_fault_flag;
    logic parity_fault_flag;
  } spc_flags_type;

  typedef struct packed {
    logic tx_empty_irq;
    logic rx_full_irq;
    logic rx_error_irq;
    logic tx_end_irq;
  } spc_irq_type;

  typedef struct packed {
    logic valid;
    logic multiproc_bit;
    logic frame_fault;
    logic overrun;
    logic parity_fault;
  } spc_rx_char_type;

endpackage

// file: logic/spc_clk_sel.sv
// Clock source decoder: selects bit timing source and serial clock pin direction
`timescale 1ns/1ps
module spc_clk_sel
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic comm_mode_i,
  input wire logic [1:0] clock_source_sel_i,
  input wire logic bit_clk_i,
  output spc_clk_mode_type clk_mode_o,
  output logic use_ext_clk_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o
);

  spc_clk_mode_type next_mode;
  spc_clk_mode_type mode;
  logic next_pin;
  logic pin;

  // ******************************************************************
  // Mode decode
  // ******************************************************************
  // Reserved codes fall back to internal timing with the pin undriven
  always_comb begin
    next_mode = SPC_CLK_RESERVED;
    if (!comm_mode_i) begin
      case (clock_source_sel_i)
        SPC_CKS_INT: next_mode = SPC_CLK_INTERNAL;
        SPC_CKS_INT_OUT: next_mode = SPC_CLK_DRIVE_OUT;
        SPC_CKS_EXT: next_mode = SPC_CLK_EXTERNAL;
        default: next_mode = SPC_CLK_RESERVED;
      endcase
    end else begin
      case (clock_source_sel_i)
        SPC_CKS_INT: next_mode = SPC_CLK_DRIVE_OUT;
        SPC_CKS_EXT: next_mode = SPC_CLK_EXTERNAL;
        default: next_mode = SPC_CLK_RESERVED;
      endcase
    end
    next_pin = (next_mode == SPC_CLK_DRIVE_OUT) ? bit_clk_i : 1'b0;
  end

  // Registered so the pin never glitches on a control write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= SPC_CLK_INTERNAL;
      pin <= 1'b0;
    end else begin
      mode <= next_mode;
      pin <= next_pin;
    end
  end

  assign clk_mode_o = mode;
  assign use_ext_clk_o = (mode == SPC_CLK_EXTERNAL);
  assign serial_clock_pin_o = pin;
  assign serial_clock_pin_oe_o = (mode == SPC_CLK_DRIVE_OUT);

endmodule

// file: logic/spc_ctrl.sv
// Serial port control: control register, enables, address filter and interrupts
//
// Overview of operation
// - Transmit empty request needs bit 7
// - Receive full and error need bit 6
// - Transmission allowed only with bit 5
// - Reception allowed only with bit 4
// - Filter wait acts only multiproc async
// - Filter wait discards characters with bit 0
// - Filter wait suppresses full, frame fault, overrun flags
// - Multiproc bit 1 clears wait, resumes
// - Transmit end request needs bit 2
// - Async code 00: internal timing, no pin
// - Async code 01: internal, drive bit clock
// - Async code 10: pin input, 16x rate
// - Sync code 00: internal clock driven out
// - Sync code 10: pin is clock input
// - Transmit disabled holds empty, end flags high
// - Receive disable keeps last multiproc bit
// - Mode bit: 0 async, 1 sync
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module spc_ctrl
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire spc_flags_type flags_i,
  input wire spc_rx_char_type rx_char_i,
  input wire logic bit_clk_i,
  output spc_flags_type flags_o,
  output spc_rx_char_type rx_char_o,
  output logic tx_allow_o,
  output logic rx_allow_o,
  output logic rx_multiproc_bit_o,
  output logic use_ext_clk_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output spc_irq_type irq_req_o,
  output logic irq_o
);

  // ******************************************************************
  // State
  // ******************************************************************
  logic [7:0] serial_ctrl_reg;
  logic [7:0] next_serial_ctrl_reg;
  logic [7:0] serial_format_reg;
  logic [7:0] next_serial_format_reg;
  logic [3:0] irq_stat;
  logic [3:0] next_irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] next_irq_mask;
  logic rx_multiproc_bit;
  logic next_rx_multiproc_bit;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  spc_irq_type irq_req;
  spc_irq_type irq_req_d;
  spc_flags_type flags_eff;
  logic filter_active;
  logic skip_char;
  logic wake_char;
  logic [3:0] rise;

  // Write decode shared by every writable register
  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target, input logic w);
    wr_hit = w && (a == target);
  endfunction

  // ******************************************************************
  // Address filter and flag shaping
  // ******************************************************************
  // The wait bit is meaningless outside multiprocessor async operation
  always_comb begin
    filter_active = serial_ctrl_reg[SPC_BIT_ADDR_FILTER_WAIT] &&
                    serial_format_reg[SPC_BIT_MULTIPROC_MODE] &&
                    !serial_format_reg[SPC_BIT_COMM_MODE];
    skip_char = filter_active && rx_char_i.valid && !rx_char_i.multiproc_bit;
    wake_char = filter_active && rx_char_i.valid && rx_char_i.multiproc_bit;
    rx_char_o = rx_char_i;
    // Filtered characters reach neither the buffer nor the frame and overrun flags
    if (skip_char || !serial_ctrl_reg[SPC_BIT_RX_ALLOW]) begin
      rx_char_o.valid = 1'b0;
    end
    // The address character itself is received with normal fault reporting
    if (filter_active && !wake_char) begin
      rx_char_o.frame_fault = 1'b0;
      rx_char_o.overrun = 1'b0;
    end
    flags_eff = flags_i;
    if (filter_active) begin
      flags_eff.rx_data_full_flag = 1'b0;
      flags_eff.frame_fault_flag = 1'b0;
      flags_eff.overrun_flag = 1'b0;
    end
    if (!serial_ctrl_reg[SPC_BIT_TX_ALLOW]) begin
      flags_eff.tx_buffer_empty_flag = 1'b1;
      flags_eff.tx_finished_flag = 1'b1;
    end
  end

  assign flags_o = flags_eff;
  assign tx_allow_o = serial_ctrl_reg[SPC_BIT_TX_ALLOW];
  assign rx_allow_o = serial_ctrl_reg[SPC_BIT_RX_ALLOW];
  assign rx_multiproc_bit_o = rx_multiproc_bit;

  // ******************************************************************
  // Interrupt requests
  // ******************************************************************
  always_comb begin
    irq_req.tx_empty_irq = serial_ctrl_reg[SPC_BIT_TX_IRQ_ALLOW] &&
                           flags_eff.tx_buffer_empty_flag;
    irq_req.rx_full_irq = serial_ctrl_reg[SPC_BIT_RX_IRQ_ALLOW] &&
                          flags_eff.rx_data_full_flag;
    irq_req.rx_error_irq = serial_ctrl_reg[SPC_BIT_RX_IRQ_ALLOW] &&
                           (flags_eff.overrun_flag || flags_eff.frame_fault_flag ||
                            flags_eff.parity_fault_flag);
    irq_req.tx_end_irq = serial_ctrl_reg[SPC_BIT_TX_DONE_IRQ_ALLOW] &&
                         flags_eff.tx_finished_flag;
    rise = 4'h0;
    rise[SPC_EV_TX_EMPTY] = irq_req.tx_empty_irq && !irq_req_d.tx_empty_irq;
    rise[SPC_EV_RX_FULL] = irq_req.rx_full_irq && !irq_req_d.rx_full_irq;
    rise[SPC_EV_RX_ERROR] = irq_req.rx_error_irq && !irq_req_d.rx_error_irq;
    rise[SPC_EV_TX_END] = irq_req.tx_end_irq && !irq_req_d.tx_end_irq;
  end

  assign irq_req_o = irq_req;
  assign irq_o = |(irq_stat & irq_mask);

  // ******************************************************************
  // Register next values
  // ******************************************************************
  // A rising request in the read cycle survives the read clear
  always_comb begin
    next_serial_ctrl_reg = serial_ctrl_reg;
    next_serial_format_reg = serial_format_reg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_rx_multiproc_bit = rx_multiproc_bit;
    next_rdata = 8'h00;
    if (wr_hit(addr_i, SPC_ADDR_CTRL, wr_i)) begin
      next_serial_ctrl_reg = wdata_i;
    end
    if (wake_char) begin
      next_serial_ctrl_reg[SPC_BIT_ADDR_FILTER_WAIT] = 1'b0;
    end
    if (wr_hit(addr_i, SPC_ADDR_FORMAT, wr_i)) begin
      next_serial_format_reg = wdata_i;
    end
    if (wr_hit(addr_i, SPC_ADDR_IRQ_MASK, wr_i)) begin
      next_irq_mask = wdata_i[3:0];
    end
    // Kept while reception is off so software can still read it
    if (serial_ctrl_reg[SPC_BIT_RX_ALLOW] && rx_char_i.valid) begin
      next_rx_multiproc_bit = rx_char_i.multiproc_bit;
    end
    if (rd_i) begin
      case (addr_i)
        SPC_ADDR_CTRL: next_rdata = serial_ctrl_reg;
        SPC_ADDR_IRQ_STAT: begin
          next_rdata = {4'h0, irq_stat};
          next_irq_stat = 4'h0;
        end
        SPC_ADDR_IRQ_MASK: next_rdata = {4'h0, irq_mask};
        SPC_ADDR_FORMAT: next_rdata = serial_format_reg;
        SPC_ADDR_PORT_STAT: next_rdata = {flags_eff.tx_buffer_empty_flag, flags_eff.rx_data_full_flag,
                                          flags_eff.overrun_flag, flags_eff.frame_fault_flag,
                                          flags_eff.parity_fault_flag, flags_eff.tx_finished_flag,
                                          rx_multiproc_bit, use_ext_clk_o};
        default: next_rdata = 8'h00;
      endcase
    end
    next_irq_stat = next_irq_stat | rise;
  end

  // Register stage only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_ctrl_reg <= SPC_CTRL_RESET;
      serial_format_reg <= SPC_FORMAT_RESET;
      irq_stat <= SPC_EV_RESET;
      irq_mask <= SPC_EV_RESET;
      rx_multiproc_bit <= 1'b0;
      rdata <= 8'h00;
      irq_req_d <= '0;
    end else begin
      serial_ctrl_reg <= next_serial_ctrl_reg;
      serial_format_reg <= next_serial_format_reg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rx_multiproc_bit <= next_rx_multiproc_bit;
      rdata <= next_rdata;
      irq_req_d <= irq_req;
    end
  end

  assign rdata_o = rdata;

  // ******************************************************************
  // Clock source selection
  // ******************************************************************
  // Low two control bits carry the clock source code
  spc_clk_sel u_clk_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .comm_mode_i(serial_format_reg[SPC_BIT_COMM_MODE]),
    .clock_source_sel_i(serial_ctrl_reg[1:0]),
    .bit_clk_i(bit_clk_i),
    .clk_mode_o(),
    .use_ext_clk_o(use_ext_clk_o),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_o(serial_clock_pin_oe_o)
  );

endmodule

// file: sim/spc_remote.sv
// Remote serial party model: character stream and link clock
`timescale 1ns/1ps
module spc_remote
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic mbit_i,
  output spc_rx_char_type char_o,
  output logic bit_clk_o
);
  logic [3:0] div;
  // Sixteen ticks per bit, free running like a rate generator
  assign bit_clk_o = div[3];
  // One character per request; the idle bit toggles so no stale value lingers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 4'h0;
      char_o <= '0;
    end else begin
      div <= div + 4'h1;
      char_o <= '{send_i, send_i ? mbit_i : ~char_o.multiproc_bit, 1'b0, 1'b0, 1'b0};
    end
  end
endmodule

// file: sim/spc_ctrl_props.sv
// Assertion checker for the serial port control block
`timescale 1ns/1ps
module spc_ctrl_props
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire spc_rx_char_type rx_char_i,
  input wire logic bit_clk_i,
  input wire spc_flags_type flags_o,
  input wire spc_rx_char_type rx_char_o,
  input wire logic tx_allow_o,
  input wire logic rx_allow_o,
  input wire logic rx_multiproc_bit_o,
  input wire logic use_ext_clk_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire spc_irq_type irq_req_o
);
  logic [7:0] ctl;
  logic [7:0] fmt;
  logic filt;
  // Wait bit only counts in async multiprocessor mode
  assign filt = ctl[3] & fmt[2] & ~fmt[7];
  // Shadow of software writes, plus the self-clear on an address character
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl <= 8'h00;
      fmt <= 8'h00;
    end else begin
      if (wr_i && addr_i == SPC_ADDR_CTRL) begin
        ctl <= wdata_i;
      end
      if (wr_i && addr_i == SPC_ADDR_FORMAT) begin
        fmt <= wdata_i;
      end
      // Hardware clear of the wait bit beats a software write in the same cycle
      if (filt && rx_char_i.valid && rx_char_i.multiproc_bit) begin
        ctl[3] <= 1'b0;
      end
    end
  end
  // *****
  // Properties
  // *****
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_tx_irq; irq_req_o.tx_empty_irq == (ctl[7] & flags_o.tx_buffer_empty_flag); endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx empty request");
  property p_rx_irq; irq_req_o.rx_full_irq == (ctl[6] & flags_o.rx_data_full_flag); endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx full request");
  property p_err_irq;
    irq_req_o.rx_error_irq ==
      (ctl[6] & (flags_o.overrun_flag | flags_o.frame_fault_flag | flags_o.parity_fault_flag));
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("rx error request");
  property p_end_irq; irq_req_o.tx_end_irq == (ctl[2] & flags_o.tx_finished_flag); endproperty
  a_end_irq: assert property (p_end_irq) else $error("tx end request");
  property p_tx_hold; !tx_allow_o |-> flags_o.tx_buffer_empty_flag && flags_o.tx_finished_flag; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flags not held");
  property p_mbit_keep; !rx_allow_o |=> $stable(rx_multiproc_bit_o); endproperty
  a_mbit_keep: assert property (p_mbit_keep) else $error("address bit moved");
  property p_rx_off; !rx_allow_o |-> !rx_char_o.valid; endproperty
  a_rx_off: assert property (p_rx_off) else $error("char while rx off");
  property p_drop; filt && rx_char_i.valid && !rx_char_i.multiproc_bit |-> !rx_char_o.valid; endproperty
  a_drop: assert property (p_drop) else $error("data char not dropped");
  property p_quiet; filt |-> !(flags_o.rx_data_full_flag || flags_o.overrun_flag || flags_o.frame_fault_flag); endproperty
  a_quiet: assert property (p_quiet) else $error("flag while waiting");
  property p_ext_in; use_ext_clk_o |-> !serial_clock_pin_oe_o; endproperty
  a_ext_in: assert property (p_ext_in) else $error("pin driven as input");
  property p_pin; serial_clock_pin_oe_o |-> serial_clock_pin_o == $past(bit_clk_i); endproperty
  a_pin: assert property (p_pin) else $error("pin clock wrong");
  c_wake: cover property (filt && rx_char_i.valid && rx_char_i.multiproc_bit);
  c_ext: cover property (use_ext_clk_o);
  c_all: cover property (irq_req_o == 4'hF);
endmodule
bind spc_ctrl spc_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rx_char_i(rx_char_i), .bit_clk_i(bit_clk_i), .flags_o(flags_o), .rx_char_o(rx_char_o), .tx_allow_o(tx_allow_o),
  .rx_allow_o(rx_allow_o), .rx_multiproc_bit_o(rx_multiproc_bit_o), .use_ext_clk_o(use_ext_clk_o),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o), .irq_req_o(irq_req_o));

// file: sim/tb_spc_ctrl.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_spc_ctrl
  import spc_pkg::*;
;
  // Enable table row: control value, raw flags, expected requests
  typedef struct packed {
    logic [7:0] ctl;
    spc_flags_type f;
    spc_irq_type e;
  } spc_row_type;
  spc_row_type rows [11] = '{{8'hE4, 6'h3F, 4'hF}, {8'h20, 6'h3F, 4'h0}, {8'hA0, 6'h20, 4'h8}, {8'hA0, 6'h10, 4'h0},
    {8'h60, 6'h04, 4'h2}, {8'h40, 6'h01, 4'h2}, {8'h40, 6'h08, 4'h4}, {8'h24, 6'h10, 4'h1}, {8'h04, 6'h00, 4'h1},
    {8'h80, 6'h00, 4'h8}, {8'hD0, 6'h02, 4'hA}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic send = 1'b0;
  logic mbit = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] rv;
  spc_flags_type flags_i = '0;
  spc_flags_type flags_o;
  spc_rx_char_type rx_char_i;
  spc_rx_char_type rx_char_o;
  spc_irq_type irq_req_o;
  logic bit_clk_i, tx_allow_o, rx_allow_o, rx_multiproc_bit_o, use_ext_clk_o;
  logic serial_clock_pin_o, serial_clock_pin_oe_o, irq_o;
  logic bclk_d;
  int fail_count = 0;
  int checks_done = 0;
  int seen = 0;

  always #2 clk_i = ~clk_i;
  // Count characters let through; sampled before this edge's updates land
  always @(posedge clk_i) if (rx_char_o.valid === 1'b1) seen++;
  // Bit clock as the pin register saw it at the last edge
  always @(posedge clk_i) bclk_d <= bit_clk_i;

  spc_ctrl dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .flags_i, .rx_char_i, .bit_clk_i,
    .flags_o, .rx_char_o, .tx_allow_o, .rx_allow_o, .rx_multiproc_bit_o, .use_ext_clk_o, .serial_clock_pin_o,
    .serial_clock_pin_oe_o, .irq_req_o, .irq_o);
  spc_remote u_remote (.clk_i, .rst_i, .send_i(send), .mbit_i(mbit), .char_o(rx_char_i), .bit_clk_o(bit_clk_i));

  // *****
  // Bus and link tasks
  // *****
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic chr(input logic m);
    @(posedge clk_i);
    send <= 1'b1;
    mbit <= m;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `CHK("tx_flags", 2'b11, {flags_o.tx_buffer_empty_flag, flags_o.tx_finished_flag})
    rd(SPC_ADDR_CTRL);
    `CHK("ctrl_reset", 8'h00, rv)
    foreach (rows[i]) begin
      @(posedge clk_i);
      flags_i <= rows[i].f;
      wr(SPC_ADDR_CTRL, rows[i].ctl);
      #1 `CHK("irq_req", rows[i].e, irq_req_o)
      `CHK("tx_allow", rows[i].ctl[5], tx_allow_o)
      `CHK("rx_allow", rows[i].ctl[4], rx_allow_o)
    end
    // Sticky status: masked, unmasked, cleared by reading
    @(posedge clk_i);
    flags_i <= '0;
    wr(SPC_ADDR_CTRL, 8'h00);
    wr(SPC_ADDR_IRQ_MASK, 8'h00);
    rd(SPC_ADDR_IRQ_STAT);
    wr(SPC_ADDR_CTRL, 8'h80);
    repeat (2) @(posedge clk_i);
    #1 `CHK("irq_masked", 1'b0, irq_o)
    wr(SPC_ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    #1 `CHK("irq_on", 1'b1, irq_o)
    rd(SPC_ADDR_IRQ_STAT);
    `CHK("irq_stat", 8'h01, rv)
    repeat (2) @(posedge clk_i);
    #1 `CHK("irq_clear", 1'b0, irq_o)
    wr(4'hF, 8'hFF);
    rd(4'hF);
    `CHK("unmapped", 8'h00, rv)
    // Address filtering in async multiprocessor mode
    wr(SPC_ADDR_CTRL, 8'h00);
    wr(SPC_ADDR_FORMAT, 8'h04);
    wr(SPC_ADDR_CTRL, 8'h58);
    flags_i <= 6'h0E;
    chr(1'b0);
    `CHK("dropped", 0, seen)
    `CHK("quiet", 2'b00, {irq_req_o.rx_full_irq, irq_req_o.rx_error_irq})
    rd(SPC_ADDR_CTRL);
    `CHK("wait_held", 8'h58, rv)
    chr(1'b1);
    `CHK("woken", 1, seen)
    `CHK("mbit", 1'b1, rx_multiproc_bit_o)
    `CHK("rx_full", 1'b1, flags_o.rx_data_full_flag)
    rd(SPC_ADDR_CTRL);
    `CHK("wait_clear", 8'h50, rv)
    // Wait cleared: full, overrun, frame and the address bit show again
    rd(SPC_ADDR_PORT_STAT);
    `CHK("port_stat", 8'hF6, rv)
    wr(SPC_ADDR_CTRL, 8'h00);
    chr(1'b0);
    `CHK("mbit_kept", 1'b1, rx_multiproc_bit_o)
    `CHK("rx_off", 1, seen)
    wr(SPC_ADDR_FORMAT, 8'h84);
    wr(SPC_ADDR_CTRL, 8'h18);
    chr(1'b0);
    `CHK("sync_pass", 2, seen)
    // Clock source codes in both modes
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        logic eo;
        eo = (m == 0) ? (c == 1) : (c == 0);
        wr(SPC_ADDR_FORMAT, {m[0], 7'h00});
        wr(SPC_ADDR_CTRL, {6'h00, c[1:0]});
        repeat (2) @(posedge clk_i);
        #1 `CHK("pin_oe", eo, serial_clock_pin_oe_o)
        `CHK("pin_clk", eo & bclk_d, serial_clock_pin_o)
        `CHK("ext_clk", c == 2, use_ext_clk_o)
      end
    end
    // Mid-run reset drops both enables and restores the forced transmit flags
    wr(SPC_ADDR_CTRL, 8'h30);
    #1 `CHK("pre_rst", 2'b11, {tx_allow_o, rx_allow_o})
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `CHK("rst_allow", 2'b00, {tx_allow_o, rx_allow_o})
    `CHK("rst_tx_flags", 2'b11, {flags_o.tx_buffer_empty_flag, flags_o.tx_finished_flag})
    rd(SPC_ADDR_CTRL);
    `CHK("rst_ctrl", 8'h00, rv)
    final_report();
  end
endmodule
